// ===== hmfc_map.vh
`ifndef HMFC_MAP_VH
`define HMFC_MAP_VH
`define HMFC_CFG_ADDR 8'hac
`define HMFC_STAT_ADDR 8'hb0
`define HMFC_HI_MSB 23
`define HMFC_HI_LSB 16
`define HMFC_LO_MSB 15
`define HMFC_LO_LSB 8
`define HMFC_DUR_MSB 7
`define HMFC_DUR_LSB 4
`define HMFC_ANY_BIT 0
`define HMFC_ADDR_BIT 1
`define HMFC_BRD_BIT 2
`define HMFC_MULT_BIT 3
`define HMFC_CFG_RESET 32'h00000000
`define HMFC_CFG_MASK 32'h00ffffff
`define HMFC_CLK_MHZ 100
`define HMFC_EXTRA_10M_NS 2200
`define HMFC_EXTRA_10M_CYC ((`HMFC_EXTRA_10M_NS * `HMFC_CLK_MHZ) / 1000)
`endif

// ===== hmfc_dur_rom.v
module hmfc_dur_rom (
    // clock
    input wire clock,
    input wire rst_b,
    // lookup
    input wire [3:0] code,
    output reg [9:0] dur_us
);
    // duration lookup held in a registered table; value is in microseconds
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dur_us <= 10'h005;
        end else begin
            case (code)
                4'h0: dur_us <= 10'h005;
                4'h1: dur_us <= 10'h00a;
                4'h2: dur_us <= 10'h00f;
                4'h3: dur_us <= 10'h019;
                4'h4: dur_us <= 10'h032;
                4'h5: dur_us <= 10'h064;
                4'h6: dur_us <= 10'h096;
                4'h7: dur_us <= 10'h0c8;
                4'h8: dur_us <= 10'h0fa;
                4'h9: dur_us <= 10'h12c;
                4'ha: dur_us <= 10'h15e;
                4'hb: dur_us <= 10'h190;
                4'hc: dur_us <= 10'h1c2;
                4'hd: dur_us <= 10'h1f4;
                4'he: dur_us <= 10'h226;
                default: dur_us <= 10'h258;
            endcase
        end
    end
endmodule

// ===== hmfc_flow_ctrl.v
// Function
// - trigger at fifo fill reaching high level
// - full duplex: one pause frame carrying pause time
// - half duplex: jam matching frames for duration
// - zero-time pause when fill below low level
// - release only after high pause, auto enabled; code also sends it with hardwired flow control alone
// - thresholds also drive hardwired flow control, full duplex only
// - backpressure lasts duration code; unused full duplex
// - nothing sent while transmitter disabled
// - affects host mac flow control only
// - any-frame bit overrides the per-type bits
// - multicast, broadcast, address bits half duplex only
// - code selects 5..600us, 10M adds 2.2us

`include "hmfc_map.vh"
module hmfc_flow_ctrl (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // mac state
    input wire [15:0] pause_time_value,
    input wire full_duplex,
    input wire speed_100,
    input wire tx_enable,
    input wire hardwired_flow_enable,
    input wire [13:0] rx_fifo_bytes,
    // receive frame start, classified
    input wire rx_frame_start,
    input wire rx_is_multicast,
    input wire rx_is_broadcast,
    input wire rx_addr_match,
    // pause request to transmitter
    output reg pause_req,
    output reg [15:0] pause_req_time,
    input wire pause_ack,
    // backpressure to the fabric port
    output reg backpressure
);
    // jam_wait re-arms after each jam so that the next matching frame starts a new jam
    localparam ST_IDLE = 2'h0;
    localparam ST_JAM_WAIT = 2'h1;
    localparam ST_JAM = 2'h2;

    reg [31:0] host_flow_control_config;
    reg [1:0] state;
    reg paused;
    reg [19:0] jam_left;
    reg [19:0] jam_cycles;
    reg [31:0] next_rdata;
    wire [9:0] dur_us;

    // bits 31:24 are reserved; the write mask keeps them at zero
    wire [7:0] flow_high_level = host_flow_control_config[`HMFC_HI_MSB:`HMFC_HI_LSB];
    wire [7:0] flow_low_level = host_flow_control_config[`HMFC_LO_MSB:`HMFC_LO_LSB];
    wire [3:0] backpressure_duration = host_flow_control_config[`HMFC_DUR_MSB:`HMFC_DUR_LSB];
    wire flow_on_any_frame = host_flow_control_config[`HMFC_ANY_BIT];
    wire flow_on_address_match = host_flow_control_config[`HMFC_ADDR_BIT];
    wire flow_on_broadcast = host_flow_control_config[`HMFC_BRD_BIT];
    wire flow_on_multicast = host_flow_control_config[`HMFC_MULT_BIT];

    // fifo byte count against level * 64 bytes, widened to avoid overflow
    wire [14:0] fill_bytes = {1'b0, rx_fifo_bytes};
    wire [14:0] high_bytes = {1'b0, flow_high_level, 6'h00};
    wire [14:0] low_bytes = {1'b0, flow_low_level, 6'h00};
    wire at_high = fill_bytes >= high_bytes;
    wire below_low = fill_bytes < low_bytes;

    wire auto_en = |host_flow_control_config[3:0];
    wire flow_en = auto_en | hardwired_flow_enable;

    // per-type enables line up bit for bit with the class lines of the frame
    wire [2:0] type_en = {flow_on_multicast, flow_on_broadcast, flow_on_address_match};
    wire [2:0] type_seen = {rx_is_multicast, rx_is_broadcast, rx_addr_match};
    wire [2:0] type_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_type
            assign type_hit[gi] = type_en[gi] & type_seen[gi];
        end
    endgenerate

    // any-frame overrides the type bits; type bits matter only in half duplex
    wire frame_match = flow_on_any_frame | (|type_hit);
    wire fd_pause_en = full_duplex & (flow_on_any_frame | hardwired_flow_enable);
    wire fd_active = tx_enable && fd_pause_en;

    // a high pause goes out once per crossing; the flag arms the single release
    wire send_high_pause = !paused && at_high;
    wire send_release = paused && below_low;

    // jamming runs only in half duplex, with the transmitter on and flow enabled
    wire hd_active = tx_enable && !full_duplex && flow_en;
    wire jam_last = jam_left <= 20'h00001;

    // the duration table sits behind a register, so a new code shows one edge later
    hmfc_dur_rom u_rom (
        .clock(clock),
        .rst_b(rst_b),
        .code(backpressure_duration),
        .dur_us(dur_us)
    );

    // widest product is 600us at 100 cycles per us, well inside 20 bits
    wire [31:0] jam_calc = {22'h000000, dur_us} * `HMFC_CLK_MHZ
        + (speed_100 ? 32'h00000000 : `HMFC_EXTRA_10M_CYC);

    // 10M mode adds a fixed 2.2us; this is the cycle count of the whole jam
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            jam_cycles <= 20'h00000;
        end else begin
            jam_cycles <= jam_calc[19:0];
        end
    end

    // read data stand only in the cycle after the strobe, zero otherwise
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `HMFC_CFG_ADDR: next_rdata = host_flow_control_config;
                `HMFC_STAT_ADDR: next_rdata = {28'h0000000, pause_req, backpressure,
                    paused, at_high};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // register port; this block only touches host mac flow control
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            host_flow_control_config <= `HMFC_CFG_RESET;
            reg_rdata <= 32'h00000000;
        end else begin
            if (reg_wr && reg_addr == `HMFC_CFG_ADDR) begin
                host_flow_control_config <= reg_wdata & `HMFC_CFG_MASK;
            end
            reg_rdata <= next_rdata;
        end
    end

    // full duplex pause handling
    // a pending request keeps its time word until the transmitter takes it
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pause_req <= 1'b0;
            pause_req_time <= 16'h0000;
            paused <= 1'b0;
        end else if (pause_req) begin
            if (pause_ack) begin
                pause_req <= 1'b0;
            end
        end else if (fd_active) begin
            if (send_high_pause) begin
                pause_req <= 1'b1;
                pause_req_time <= pause_time_value;
                paused <= 1'b1;
            end else if (send_release) begin
                pause_req <= 1'b1;
                pause_req_time <= 16'h0000;
                paused <= 1'b0;
            end
        end else if (!flow_en) begin
            // disabling flow control forgets the pending release
            paused <= 1'b0;
        end
    end

    // half duplex jamming
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            backpressure <= 1'b0;
            jam_left <= 20'h00000;
        end else if (!hd_active) begin
            state <= ST_IDLE;
            backpressure <= 1'b0;
            jam_left <= 20'h00000;
        end else begin
            case (state)
                ST_IDLE: begin
                    // a jam is armed only while the fill sits at or above the high level
                    if (at_high) begin
                        state <= ST_JAM_WAIT;
                    end
                end
                ST_JAM_WAIT: begin
                    // the fill may drop below the high level while waiting for a frame
                    if (!at_high) begin
                        state <= ST_IDLE;
                    end else if (rx_frame_start && frame_match) begin
                        state <= ST_JAM;
                        backpressure <= 1'b1;
                        jam_left <= jam_cycles;
                    end
                end
                ST_JAM: begin
                    // frames that arrive during a jam are covered by it
                    if (jam_last) begin
                        state <= ST_JAM_WAIT;
                        backpressure <= 1'b0;
                        jam_left <= 20'h00000;
                    end else begin
                        jam_left <= jam_left - 20'h00001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    backpressure <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ===== hmfc_fabric_model.sv
module hmfc_fabric_model (
    // transmitter handshake and frame source
    input logic clock, rst_b, pause_req, slow, send,
    input logic [2:0] kind,
    output logic pause_ack, rx_frame_start, rx_is_multicast, rx_is_broadcast, rx_addr_match
);
    timeunit 1ns / 1ps;
    logic [3:0] age;
    logic [2:0] cls;
    assign {rx_is_multicast, rx_is_broadcast, rx_addr_match} = cls;
    always @(posedge clock or negedge rst_b)
        if (!rst_b)
            {age, cls, pause_ack, rx_frame_start} <= 9'h0;
        else begin
            // ack after two or ten cycles, as a busy transmitter might
            age <= pause_req && !pause_ack ? age + 4'h1 : 4'h0;
            pause_ack <= pause_req && !pause_ack && age >= (slow ? 4'h9 : 4'h1);
            rx_frame_start <= send;
            // class lines flip between frames so a stale value cannot pass
            cls <= send ? kind : ~cls;
        end
endmodule

// ===== hmfc_flow_ctrl_chk.sv
module hmfc_flow_ctrl_chk (
    // block inputs
    input logic clock, rst_b, reg_wr, full_duplex, tx_enable, hardwired_flow_enable,
    input logic rx_frame_start, rx_is_multicast, rx_is_broadcast, rx_addr_match, pause_ack,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic [15:0] pause_time_value,
    input logic [13:0] rx_fifo_bytes,
    // block outputs
    input logic pause_req, backpressure,
    input logic [15:0] pause_req_time
);
    timeunit 1ns / 1ps;
    logic [23:0] cfg;
    wire [13:0] hi = {cfg[23:16], 6'h0};
    wire hit = |(cfg[3:0] & {rx_is_multicast, rx_is_broadcast, rx_addr_match, 1'b1});
    always @(posedge clock or negedge rst_b)
        if (!rst_b)
            cfg <= 24'h0;
        else if (reg_wr && reg_addr == 8'hac)
            cfg <= reg_wdata[23:0];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    pause_hold_a: assert property (pause_req && !pause_ack |=> pause_req)
        else $error("pause dropped early");
    pause_once_a: assert property (pause_req && pause_ack |=> !pause_req)
        else $error("pause held after ack");
    pause_time_a: assert property (pause_req && !pause_ack |=> $stable(pause_req_time))
        else $error("pause time moved");
    high_pause_a: assert property ($rose(pause_req) && pause_req_time != 16'h0 |->
        $past(rx_fifo_bytes >= hi) && pause_req_time == $past(pause_time_value))
        else $error("bad high pause");
    zero_pause_a: assert property ($rose(pause_req) && pause_req_time == 16'h0 |->
        $past(rx_fifo_bytes < {cfg[15:8], 6'h0}))
        else $error("bad release");
    pause_tx_a: assert property ($rose(pause_req) |-> $past(tx_enable))
        else $error("pause with tx off");
    jam_cause_a: assert property ($rose(backpressure) |-> $past(tx_enable && !full_duplex
        && rx_frame_start && (hit || hardwired_flow_enable) && rx_fifo_bytes >= hi))
        else $error("jam without cause");
    jam_hold_a: assert property ($rose(backpressure) |-> backpressure [*8])
        else $error("jam too short");
    cover property ($rose(pause_req) && pause_req_time == 16'h0);
    cover property ($fell(backpressure));
    cover property (pause_req && pause_ack);
endmodule

// ===== tb_host_mac_auto_flow_control.sv
module tb_host_mac_auto_flow_control;
    timeunit 1ns / 1ps;
    logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, full_duplex = 1, speed_100 = 1;
    logic tx_enable = 1, hardwired_flow_enable = 0, send = 0, slow = 0, pause_req, pause_ack;
    logic rx_frame_start, rx_is_multicast, rx_is_broadcast, rx_addr_match, backpressure;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [15:0] pause_time_value = 16'h1, pause_req_time;
    logic [13:0] rx_fifo_bytes = 14'h0;
    logic [2:0] kind = 3'h0;
    logic [3:0] c;
    int err_total = 0, check_count = 0, n;
    always #5 clock = ~clock;
    hmfc_flow_ctrl hmfc_flow_ctrl_i (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pause_time_value(pause_time_value), .full_duplex(full_duplex), .speed_100(speed_100),
        .tx_enable(tx_enable), .hardwired_flow_enable(hardwired_flow_enable),
        .rx_fifo_bytes(rx_fifo_bytes), .rx_frame_start(rx_frame_start),
        .rx_is_multicast(rx_is_multicast), .rx_is_broadcast(rx_is_broadcast),
        .rx_addr_match(rx_addr_match), .pause_req(pause_req), .pause_req_time(pause_req_time),
        .pause_ack(pause_ack), .backpressure(backpressure)
    );
    hmfc_fabric_model hmfc_fabric_model_i (
        .clock(clock), .rst_b(rst_b), .pause_req(pause_req), .slow(slow), .send(send),
        .kind(kind), .pause_ack(pause_ack), .rx_frame_start(rx_frame_start),
        .rx_is_multicast(rx_is_multicast), .rx_is_broadcast(rx_is_broadcast),
        .rx_addr_match(rx_addr_match)
    );
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] v);
        @(posedge clock);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, v};
        @(posedge clock);
        {reg_wr, reg_rd} <= 2'h0;
        #1;
        if (!wr)
            cmp("reg_rdata", v, reg_rdata);
        @(posedge clock);
    endtask
    task automatic pause(logic exp, logic [15:0] t);
        for (n = 0; n < 40 && pause_req !== 1'b1; n++)
            @(posedge clock) #1;
        cmp("pause_req", exp, pause_req);
        if (exp)
            cmp("pause_time", t, pause_req_time);
        for (n = 0; n < 40 && pause_req === 1'b1; n++)
            @(posedge clock) #1;
        if (n == 40) begin
            err_total++;
            print_verdict;
        end
        @(posedge clock);
    endtask
    task automatic jam(logic [2:0] k, int len);
        @(posedge clock);
        {send, kind} <= {1'b1, k};
        @(posedge clock);
        send <= 1'b0;
        for (n = 0; n < 4 && backpressure !== 1'b1; n++)
            @(posedge clock) #1;
        for (n = 0; n < 9000 && backpressure === 1'b1; n++)
            @(posedge clock) #1;
        cmp("jam_cycles", len, n);
        if (n == 9000) begin
            err_total++;
            print_verdict;
        end
        @(posedge clock);
    endtask
    // jam length in clock cycles; the slow link adds 2.2 us
    function automatic int dur(logic [3:0] v);
        return 100 * (v < 3 ? 5 * (v + 1) : v == 3 ? 25 : 50 * (v - 3)) + (speed_100 ? 0 : 220);
    endfunction
    initial begin
        void'($urandom(19856));
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        d = {8'h0, 8'hff, 8'($urandom % 255), 8'($urandom)};
        pause_time_value <= 16'($urandom) | 16'h1;
        bus(1, 8'hac, d);
        bus(0, 8'hac, d);
        bus(0, 8'h10, 32'h0);
        bus(1, 8'hac, 32'h00040201);
        pause(0, 0);
        {tx_enable, rx_fifo_bytes} <= {1'b0, 14'h100};
        pause(0, 0);
        {tx_enable, slow} <= 2'h3;
        pause(1, pause_time_value);
        pause(0, 0);
        rx_fifo_bytes <= 14'h7f;
        pause(1, 0);
        bus(1, 8'hac, 32'h00040200);
        {hardwired_flow_enable, rx_fifo_bytes} <= {1'b1, 14'h100};
        pause(1, pause_time_value);
        bus(0, 8'hb0, 32'h3);
        {full_duplex, hardwired_flow_enable} <= 2'h0;
        c = 4'($urandom % 4);
        for (int i = 0; i < 3; i++) begin
            speed_100 <= i < 2;
            bus(1, 8'hac, {16'h0402, c, i < 2 ? 4'h2 : 4'h1});
            jam(i == 0 ? 3'h4 : 3'(i == 1), i ? dur(c) : 0);
        end
        print_verdict;
    end
endmodule
bind hmfc_flow_ctrl hmfc_flow_ctrl_chk hmfc_flow_ctrl_chk_i (
    .clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .full_duplex(full_duplex),
    .tx_enable(tx_enable), .hardwired_flow_enable(hardwired_flow_enable),
    .rx_frame_start(rx_frame_start), .rx_is_multicast(rx_is_multicast),
    .rx_is_broadcast(rx_is_broadcast), .rx_addr_match(rx_addr_match), .pause_ack(pause_ack),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pause_time_value(pause_time_value),
    .rx_fifo_bytes(rx_fifo_bytes), .pause_req(pause_req), .backpressure(backpressure),
    .pause_req_time(pause_req_time)
);
